// ==== period_match_timer_pkg.sv ====
// Constants, field layouts and helpers of the period-match timer
package period_match_timer_pkg;

  // ****************************************
  // Bus geometry and register offsets
  // ****************************************
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 32;
  localparam logic [4:0]  OFS_CONTROL     = 5'h00;
  localparam logic [4:0]  OFS_COUNT       = 5'h04;
  localparam logic [4:0]  OFS_PERIOD      = 5'h08;
  localparam logic [4:0]  OFS_FLAG        = 5'h0C;
  localparam logic [4:0]  OFS_ENABLE      = 5'h10;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int          PRE_LSB         = 0;
  localparam int          ON_BIT          = 2;
  localparam int          POST_LSB        = 3;
  localparam logic [7:0]  CONTROL_MASK    = 8'h7F;
  localparam int          FLAG_BIT        = 1;
  localparam int          ENABLE_BIT      = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  RST_CONTROL     = 8'h00;
  localparam logic [7:0]  RST_COUNT       = 8'h00;
  localparam logic [7:0]  RST_PERIOD      = 8'hFF;

  // ****************************************
  // Prescaler terminal counts
  // ****************************************
  localparam logic [3:0]  PRE_LAST_1      = 4'h0;
  localparam logic [3:0]  PRE_LAST_4      = 4'h3;
  localparam logic [3:0]  PRE_LAST_16     = 4'hF;

  // Last prescaler count before a tick, per select code
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    if (sel[1]) begin
      return PRE_LAST_16;
    end else if (sel[0]) begin
      return PRE_LAST_4;
    end
    return PRE_LAST_1;
  endfunction

endpackage

// ==== timer_prescaler.sv ====
// Clock prescaler of 1, 4 or 16 ahead of the period-match timer
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
  import period_match_timer_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic       clear_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  wire  [3:0] last_w = pre_last(sel_i);
  wire        end_w  = (cnt_r >= last_w);

  // Clear suppresses the tick so a control or count write never races a count
  assign tick_o  = run_i & ~clear_i & end_w;
  assign cnt_nxt = clear_i ? 4'h0 : ~run_i ? cnt_r : end_w ? 4'h0 : cnt_r + 4'h1;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  property p_pre_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clear_i |=> (cnt_r == 4'h0);
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

  property p_pre_div1;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (run_i && !clear_i && sel_i == 2'b00) |-> tick_o;
  endproperty
  a_pre_div1: assert property (p_pre_div1) else $error("divide by one missed a tick");

  property p_pre_div4;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (tick_o && sel_i == 2'b01) ##1 (run_i && !clear_i && sel_i == 2'b01) [*4]
      |-> tick_o;
  endproperty
  a_pre_div4: assert property (p_pre_div4) else $error("divide by four wrong");

endmodule
`default_nettype wire

// ==== timer_postscaler.sv ====
// Four-bit match postscaler, 1:1 to 1:16
`timescale 1ns/1ps
`default_nettype none
module timer_postscaler
  import period_match_timer_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       match_i,
  input  wire logic       clear_i,
  input  wire logic [3:0] sel_i,
  output logic            event_o
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  wire        end_w = (cnt_r >= sel_i);

  assign event_o = match_i & end_w;
  assign cnt_nxt = clear_i ? 4'h0 : ~match_i ? cnt_r : end_w ? 4'h0 : cnt_r + 4'h1;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  property p_post_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clear_i |=> (cnt_r == 4'h0);
  endproperty
  a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared");

  property p_post_count;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (match_i && !clear_i && cnt_r < sel_i) |-> !event_o ##1 (cnt_r == $past(cnt_r) + 4'h1);
  endproperty
  a_post_count: assert property (p_post_count) else $error("postscaler count wrong");

endmodule
`default_nettype wire

// ==== period_match_timer_8bit.sv ====
// Eight-bit period-match timer with AXI4-Lite register access
//
// Operation
// - While on, count rises from zero once per prescaled instruction-clock tick.
// - Prescale code 00 divides by 1, 01 by 4, 1x by 16.
// - Count is compared with period each tick; equality gives a match pulse.
// - After a match the count reloads zero, giving period plus one ticks.
// - Each match advances a four-bit postscaler that emits events.
// - Postscale field bits 6..3 holds matches per event minus one.
// - Each postscaler event sets a sticky match flag until software clears it.
// - Interrupt output only follows the flag while the enable bit is one.
// - Reset clears the count and sets the period to all ones.
// - Writes to count or control, and reset, clear both scaler counters.
// - Writing the control register leaves the count unchanged.
// - Control bit 2 runs the timer; zero stops it.
// - Count and period are readable and writable at any time.
// - Control bit 7 reads zero; implemented control bits reset to zero.
// - Match pulse is offered as a shift clock to the serial port.
// - Unscaled match pulse is the time base of capture/compare units.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer_8bit
  import period_match_timer_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic                   pwm_timebase_o,
  output logic                   ssp_shift_clk_o,
  output logic                   match_irq_o
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return (a == OFS_CONTROL) || (a == OFS_COUNT) || (a == OFS_PERIOD) ||
           (a == OFS_FLAG) || (a == OFS_ENABLE);
  endfunction

  // ****************************************
  // Bus slave state
  // ****************************************
  logic              awready_r;
  logic              wready_r;
  logic              have_aw_r;
  logic              have_w_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [DATA_W-1:0] rdata_r;

  // ****************************************
  // Timer state
  // ****************************************
  logic [7:0] control_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] period_r;
  logic       flag_r;
  logic       flag_nxt;
  logic       enable_r;
  logic       match_r;
  logic       irq_r;
  logic       tick_w;
  logic       post_event_w;

  wire aw_hs = s_axi_awvalid_i & awready_r;
  wire w_hs  = s_axi_wvalid_i & wready_r;
  wire b_hs  = bvalid_r & s_axi_bready_i;
  wire ar_hs = s_axi_arvalid_i & arready_r;
  wire r_hs  = rvalid_r & s_axi_rready_i;

  // Write fires once both halves are held and no response is pending
  wire do_wr     = have_aw_r & have_w_r & ~bvalid_r;
  wire wr_lane   = do_wr & wlane_r;
  wire wr_ctrl   = wr_lane & (waddr_r == OFS_CONTROL);
  wire wr_count  = wr_lane & (waddr_r == OFS_COUNT);
  wire wr_period = wr_lane & (waddr_r == OFS_PERIOD);
  wire wr_flag   = wr_lane & (waddr_r == OFS_FLAG);
  wire wr_enable = wr_lane & (waddr_r == OFS_ENABLE);

  wire       timer_on     = control_r[ON_BIT];
  wire [1:0] prescale_sel = control_r[PRE_LSB +: 2];
  wire [3:0] postscale_sel = control_r[POST_LSB +: 4];
  wire       scaler_clear = wr_ctrl | wr_count;
  wire       match_now    = (count_r == period_r);
  wire       match_pulse  = tick_w & match_now;

  // ****************************************
  // Read data selection
  // ****************************************
  wire [7:0] rd_byte =
    (s_axi_araddr_i == OFS_CONTROL) ? (control_r & CONTROL_MASK) :
    (s_axi_araddr_i == OFS_COUNT)   ? count_r :
    (s_axi_araddr_i == OFS_PERIOD)  ? period_r :
    (s_axi_araddr_i == OFS_FLAG)    ? (8'h00 | {6'h00, flag_r, 1'b0}) :
    (s_axi_araddr_i == OFS_ENABLE)  ? {6'h00, enable_r, 1'b0} : 8'h00;

  // ****************************************
  // Counter datapath
  // ****************************************
  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = wbyte_r;
    end else if (match_pulse) begin
      count_nxt = RST_COUNT;
    end else if (tick_w) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (wr_flag) begin
      flag_nxt = wbyte_r[FLAG_BIT];
    end
    if (post_event_w) begin
      flag_nxt = 1'b1;
    end
  end

  timer_prescaler u_prescaler (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .run_i     (timer_on),
    .clear_i   (scaler_clear),
    .sel_i     (prescale_sel),
    .tick_o    (tick_w)
  );

  timer_postscaler u_postscaler (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .match_i   (match_pulse),
    .clear_i   (scaler_clear),
    .sel_i     (postscale_sel),
    .event_o   (post_event_w)
  );

  // ****************************************
  // Write channel
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      have_aw_r <= 1'b0;
      have_w_r  <= 1'b0;
      waddr_r   <= '0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready_r <= 1'b0;
        have_aw_r <= 1'b1;
        waddr_r   <= s_axi_awaddr_i;
      end else if (do_wr) begin
        have_aw_r <= 1'b0;
      end else if (b_hs) begin
        awready_r <= 1'b1;
      end
      if (w_hs) begin
        wready_r <= 1'b0;
        have_w_r <= 1'b1;
        wbyte_r  <= s_axi_wdata_i[7:0];
        wlane_r  <= s_axi_wstrb_i[0];
      end else if (do_wr) begin
        have_w_r <= 1'b0;
      end else if (b_hs) begin
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= reg_hit(waddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= reg_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      rdata_r   <= {24'h000000, rd_byte};
    end else if (r_hs) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // ****************************************
  // Timer registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_r <= RST_CONTROL;
      count_r   <= RST_COUNT;
      period_r  <= RST_PERIOD;
      flag_r    <= 1'b0;
      enable_r  <= 1'b0;
      match_r   <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        control_r <= wbyte_r & CONTROL_MASK;
      end
      if (wr_period) begin
        period_r <= wbyte_r;
      end
      if (wr_enable) begin
        enable_r <= wbyte_r[ENABLE_BIT];
      end
      count_r <= count_nxt;
      flag_r  <= flag_nxt;
      match_r <= match_pulse;
      irq_r   <= flag_r & enable_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = rdata_r;
  assign pwm_timebase_o  = match_r;
  assign ssp_shift_clk_o = match_r;
  assign match_irq_o     = irq_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_tick_at_period;
    tick_w && (count_r == period_r);
  endsequence

  sequence s_tick_below_period;
    tick_w && (count_r != period_r);
  endsequence

  property p_count_step;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_tick_below_period |=> (count_r == $past(count_r) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_match_out;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_tick_at_period |=> pwm_timebase_o && ssp_shift_clk_o;
  endproperty
  a_match_out: assert property (p_match_out) else $error("match pulse missing");

  property p_match_only_at_period;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    pwm_timebase_o |-> $past(count_r) == $past(period_r);
  endproperty
  a_match_only_at_period: assert property (p_match_only_at_period) else $error("stray match");

  property p_wrap_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_tick_at_period |=> (count_r == 8'h00);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("count not reloaded");

  property p_flag_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    post_event_w |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by event");

  property p_flag_sticky;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    flag_r && !wr_flag |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_irq_gate;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 (match_irq_o == ($past(flag_r) && $past(enable_r)));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

  property p_ctrl_keeps_count;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_ctrl |=> $stable(count_r);
  endproperty
  a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) else $error("count moved");

  property p_off_holds;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !timer_on && !wr_count |=> $stable(count_r) && !pwm_timebase_o;
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("stopped timer moved");

  property p_bit7_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    control_r[7] == 1'b0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 set");

  property p_count_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_count |=> (count_r == $past(wbyte_r));
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

endmodule
`default_nettype wire

// ==== timebase_sink.sv ====
// Capture/compare and serial-port side model that consumes the match pulse
`timescale 1ns/1ps
`default_nettype none
module timebase_sink (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic pwm_timebase_i,
  input  wire logic ssp_shift_clk_i,
  output int        pulse_cnt_o,
  output int        gap_o,
  output int        skew_cnt_o
);
  int since_r;

  // ****************************************
  // Pulse counting and spacing
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_r     <= 0;
      pulse_cnt_o <= 0;
      gap_o       <= 0;
      skew_cnt_o  <= 0;
    end else begin
      since_r <= since_r + 1;
      if (pwm_timebase_i !== ssp_shift_clk_i) begin
        skew_cnt_o <= skew_cnt_o + 1;
      end
      if (pwm_timebase_i === 1'h1) begin
        pulse_cnt_o <= pulse_cnt_o + 1;
        gap_o       <= since_r + 1;
        since_r     <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_period_match_timer_8bit.sv ====
// Self-checking bench of the period-match timer over its register bus
`timescale 1ns/1ps
`default_nettype none
module tb_period_match_timer_8bit
  import period_match_timer_pkg::*;
;
  logic              clk_sys_i = 1'h0;
  logic              rst_n_i   = 1'h0;
  logic [ADDR_W-1:0] aw_addr   = '0;
  logic              aw_valid  = 1'h0;
  logic [DATA_W-1:0] w_data    = '0;
  logic              w_valid   = 1'h0;
  logic              b_ready   = 1'h0;
  logic [ADDR_W-1:0] ar_addr   = '0;
  logic              ar_valid  = 1'h0;
  logic              r_ready   = 1'h0;
  logic              aw_ready;
  logic              w_ready;
  logic [1:0]        b_resp;
  logic              b_valid;
  logic              ar_ready;
  logic [DATA_W-1:0] r_data;
  logic [1:0]        r_resp;
  logic              r_valid;
  logic              pwm_tb;
  logic              ssp_clk;
  logic              irq;
  int                pulse_cnt;
  int                gap;
  int                skew;
  int                fails       = 0;
  int                check_count = 0;
  int                div_tab [4] = '{1, 4, 16, 16};

  period_match_timer_8bit i_period_match_timer_8bit (
    .clk_sys_i       (clk_sys_i),
    .rst_n_i         (rst_n_i),
    .s_axi_awaddr_i  (aw_addr),
    .s_axi_awprot_i  (3'h0),
    .s_axi_awvalid_i (aw_valid),
    .s_axi_awready_o (aw_ready),
    .s_axi_wdata_i   (w_data),
    .s_axi_wstrb_i   (4'h1),
    .s_axi_wvalid_i  (w_valid),
    .s_axi_wready_o  (w_ready),
    .s_axi_bresp_o   (b_resp),
    .s_axi_bvalid_o  (b_valid),
    .s_axi_bready_i  (b_ready),
    .s_axi_araddr_i  (ar_addr),
    .s_axi_arprot_i  (3'h0),
    .s_axi_arvalid_i (ar_valid),
    .s_axi_arready_o (ar_ready),
    .s_axi_rdata_o   (r_data),
    .s_axi_rresp_o   (r_resp),
    .s_axi_rvalid_o  (r_valid),
    .s_axi_rready_i  (r_ready),
    .pwm_timebase_o  (pwm_tb),
    .ssp_shift_clk_o (ssp_clk),
    .match_irq_o     (irq)
  );

  timebase_sink i_timebase_sink (
    .clk_sys_i       (clk_sys_i),
    .rst_n_i         (rst_n_i),
    .pwm_timebase_i  (pwm_tb),
    .ssp_shift_clk_i (ssp_clk),
    .pulse_cnt_o     (pulse_cnt),
    .gap_o           (gap),
    .skew_cnt_o      (skew)
  );

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] ctl(input logic [3:0] po, input logic on, input logic [1:0] pr);
    return {1'h0, po, on, pr};
  endfunction

  task automatic axi_wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    logic       ah;
    logic       wh;
    logic       bh;
    logic [1:0] rsp;
    int         n;
    bh = 1'h0;
    n  = 0;
    @(posedge clk_sys_i);
    aw_addr  <= a;
    w_data   <= {24'h000000, d};
    aw_valid <= 1'h1;
    w_valid  <= 1'h1;
    b_ready  <= 1'h1;
    while (!bh && n < 100) begin
      @(negedge clk_sys_i);
      ah  = aw_valid & aw_ready;
      wh  = w_valid & w_ready;
      bh  = b_valid;
      rsp = b_resp;
      @(posedge clk_sys_i);
      if (ah) aw_valid <= 1'h0;
      if (wh) w_valid <= 1'h0;
      if (bh) b_ready <= 1'h0;
      n++;
    end
    if (!bh) fails++;
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ah;
    logic        rh;
    logic [31:0] d;
    logic [1:0]  rsp;
    int          n;
    rh = 1'h0;
    n  = 0;
    @(posedge clk_sys_i);
    ar_addr  <= a;
    ar_valid <= 1'h1;
    r_ready  <= 1'h1;
    while (!rh && n < 100) begin
      @(negedge clk_sys_i);
      ah  = ar_valid & ar_ready;
      rh  = r_valid;
      d   = r_data;
      rsp = r_resp;
      @(posedge clk_sys_i);
      if (ah) ar_valid <= 1'h0;
      if (rh) r_ready <= 1'h0;
      n++;
    end
    if (!rh) fails++;
    chk(d, ed);
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  task automatic wait_pulses(input int k);
    int s;
    int n;
    s = pulse_cnt;
    n = 0;
    while (pulse_cnt < s + k && n < 3000) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (pulse_cnt < s + k) fails++;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 500) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (irq !== 1'h1) fails++;
  endtask

  task automatic chk_irq(input logic e);
    repeat (3) @(negedge clk_sys_i);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // ****************************************
  // Clock, watchdog and test sequence
  // ****************************************
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #400000;
    fails++;
    close_out();
  end

  initial begin
    int s;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    rd_chk(OFS_CONTROL, 32'h00, RESP_OKAY);
    rd_chk(OFS_COUNT, 32'h00, RESP_OKAY);
    rd_chk(OFS_PERIOD, 32'hFF, RESP_OKAY);
    rd_chk(OFS_FLAG, 32'h00, RESP_OKAY);
    rd_chk(OFS_ENABLE, 32'h00, RESP_OKAY);
    rd_chk(5'h14, 32'h00, RESP_SLVERR);
    axi_wr(5'h14, 8'hFF, RESP_SLVERR);
    $display("test reset_values done");
    axi_wr(OFS_CONTROL, 8'hFB, RESP_OKAY);
    rd_chk(OFS_CONTROL, 32'h7B, RESP_OKAY);
    axi_wr(OFS_COUNT, 8'h5A, RESP_OKAY);
    axi_wr(OFS_PERIOD, 8'hA5, RESP_OKAY);
    s = pulse_cnt;
    axi_wr(OFS_CONTROL, 8'h78, RESP_OKAY);
    repeat (30) @(posedge clk_sys_i);
    rd_chk(OFS_COUNT, 32'h5A, RESP_OKAY);
    rd_chk(OFS_PERIOD, 32'hA5, RESP_OKAY);
    chk(32'(pulse_cnt), 32'(s));
    $display("test access_stopped done");
    axi_wr(OFS_PERIOD, 8'h04, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      axi_wr(OFS_CONTROL, 8'h00, RESP_OKAY);
      axi_wr(OFS_COUNT, 8'h00, RESP_OKAY);
      axi_wr(OFS_CONTROL, ctl(4'h0, 1'h1, c[1:0]), RESP_OKAY);
      wait_pulses(3);
      chk(32'(gap), 32'(5 * div_tab[c]));
    end
    axi_wr(OFS_PERIOD, 8'h00, RESP_OKAY);
    axi_wr(OFS_CONTROL, ctl(4'h0, 1'h1, 2'h1), RESP_OKAY);
    wait_pulses(3);
    chk(32'(gap), 32'h4);
    chk(32'(skew), 32'h0);
    $display("test period_prescale done");
    axi_wr(OFS_PERIOD, 8'h01, RESP_OKAY);
    axi_wr(OFS_ENABLE, 8'h02, RESP_OKAY);
    for (int k = 0; k < 16; k++) begin
      axi_wr(OFS_CONTROL, 8'h00, RESP_OKAY);
      axi_wr(OFS_COUNT, 8'h00, RESP_OKAY);
      axi_wr(OFS_FLAG, 8'h00, RESP_OKAY);
      s = pulse_cnt;
      axi_wr(OFS_CONTROL, ctl(k[3:0], 1'h1, 2'h0), RESP_OKAY);
      wait_irq();
      chk(32'(pulse_cnt - s), 32'(k + 1));
    end
    axi_wr(OFS_CONTROL, 8'h00, RESP_OKAY);
    axi_wr(OFS_ENABLE, 8'h00, RESP_OKAY);
    chk_irq(1'h0);
    rd_chk(OFS_FLAG, 32'h02, RESP_OKAY);
    axi_wr(OFS_ENABLE, 8'h02, RESP_OKAY);
    chk_irq(1'h1);
    axi_wr(OFS_FLAG, 8'h00, RESP_OKAY);
    rd_chk(OFS_FLAG, 32'h00, RESP_OKAY);
    chk_irq(1'h0);
    $display("test postscale_flag done");
    axi_wr(OFS_PERIOD, 8'h09, RESP_OKAY);
    axi_wr(OFS_COUNT, 8'h00, RESP_OKAY);
    axi_wr(OFS_CONTROL, ctl(4'h3, 1'h1, 2'h0), RESP_OKAY);
    wait_pulses(2);
    axi_wr(OFS_COUNT, 8'h00, RESP_OKAY);
    s = pulse_cnt;
    wait_irq();
    chk(32'(pulse_cnt - s), 32'h4);
    $display("test count_write_clear done");
    axi_wr(OFS_PERIOD, 8'h3C, RESP_OKAY);
    @(posedge clk_sys_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    rd_chk(OFS_PERIOD, 32'hFF, RESP_OKAY);
    rd_chk(OFS_COUNT, 32'h00, RESP_OKAY);
    rd_chk(OFS_CONTROL, 32'h00, RESP_OKAY);
    chk_irq(1'h0);
    $display("test second_reset done");
    close_out();
  end
endmodule
`default_nettype wire
